// ===== hw/rio_pkg.sv
package rio_pkg;
  // Clock and input filter timing
  localparam int CLK_MHZ = 100;
  localparam int DEB_TIME_US = 100;
  localparam int DEB_CYC = DEB_TIME_US * CLK_MHZ;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_THRESH = 8'h04;
  localparam logic [7:0] A_OV_LIM = 8'h08;
  localparam logic [7:0] A_OC_LIM = 8'h0C;
  localparam logic [7:0] A_OP_LIM = 8'h10;
  localparam logic [7:0] A_TRIP = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_IRQ_ST = 8'h1C;
  localparam logic [7:0] A_IRQ_MSK = 8'h20;
  localparam logic [7:0] A_CMD = 8'h24;
  // Control register fields
  localparam int CB_PROG = 0;
  localparam int CB_A_INH = 1;
  localparam int CB_B_INH = 2;
  localparam int CB_SERIES = 3;
  // Command register fields
  localparam int CMD_ON = 0;
  localparam int CMD_OFF = 1;
  // Ratings and settable caps (1.1 x V, 1.1 x I, 1.05 x P)
  localparam logic [16:0] RATED_V = 17'h03E80;
  localparam logic [16:0] RATED_I = 17'h01F40;
  localparam logic [16:0] RATED_P = 17'h07530;
  localparam logic [16:0] CAP_V = RATED_V + RATED_V / 17'h0000A;
  localparam logic [16:0] CAP_I = RATED_I + RATED_I / 17'h0000A;
  localparam logic [16:0] CAP_P = RATED_P + RATED_P / 17'h00014;
  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] RISE_RST = 16'h0100;
  localparam logic [15:0] FALL_RST = 16'h0080;
  localparam logic [15:0] OV_RST = RATED_V[15:0];
  localparam logic [15:0] OC_RST = RATED_I[15:0];
  localparam logic [15:0] OP_RST = RATED_P[15:0];
  localparam logic [7:0] IRQ_MSK_RST = 8'h00;
  localparam logic [4:0] PINS_RST = 5'h0F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic interlock;
    logic trig;
    logic topo;
    logic ctl_b;
    logic ctl_a;
  } rio_pins_t;

  typedef struct packed {
    logic inhibit;
    logic fan;
    logic ot;
    logic sop;
    logic soc;
    logic ov;
  } rio_trip_t;
endpackage : rio_pkg

// ===== hw/rio_top.sv
// Summary of operation
// - Live flag with rise/fall voltage hysteresis
// - Enabled status high while output on
// - Mode output high CV, low CC
// - Both control lines high off, low on
// - Inhibit low switches off, raises indication
// - Inhibit stays latched, blocks load on
// - Control input changes acted on within 5ms
// - Topology key guards series versus parallel wiring
// - Fault line low during any protection
// - Trigger falling edge advances program sequence
// - Overtemp output low during overtemperature
// - Interlock input temporarily switches output off
// - Fan stall trip latched until cleared
// - Overvoltage trip; limit above 1.1x rejected
// - Source overcurrent trip; limit capped 1.1x
// - Source overpower trip; limit capped 1.05x
// - Overtemp trip reported on both lines
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module rio_top
  import rio_pkg::*;
#(
  parameter int DEB_CYC_P = DEB_CYC
)(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Connector inputs, asynchronous
  input wire logic ext_control_in_a,
  input wire logic ext_control_in_b,
  input wire logic topology_key,
  input wire logic sequence_trigger_in,
  input wire logic interlock_in,
  // Power stage state, same clock
  input wire logic [15:0] meas_voltage,
  input wire logic [15:0] meas_current,
  input wire logic [15:0] meas_power,
  input wire logic source_mode,
  input wire logic cv_mode,
  input wire logic temp_high,
  input wire logic fan_abnormal,
  input wire logic foldback,
  input wire logic input_ov,
  input wire logic input_uv,
  // Connector outputs
  output logic output_live_flag,
  output logic output_enabled_status,
  output logic regulation_mode_out,
  output logic overtemp_out_n,
  output logic fault_n,
  // Power stage control and events
  output logic output_on,
  output logic seq_advance,
  output logic irq
);

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  function automatic logic fits(input logic [15:0] v, input logic [16:0] cap);
    return {1'b0, v} <= cap;
  endfunction : fits

  // Input synchroniser and debounce
  rio_pins_t pins_s1_r, pins_s2_r, pins_s3_r, filt_r, filt_d_r;
  logic [15:0] deb_cnt_r [5];
  wire rio_pins_t pins_raw = '{interlock: interlock_in, trig: sequence_trigger_in,
                               topo: topology_key, ctl_b: ext_control_in_b,
                               ctl_a: ext_control_in_a};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pins_s1_r <= PINS_RST;
      pins_s2_r <= PINS_RST;
      pins_s3_r <= PINS_RST;
      filt_r <= PINS_RST;
      filt_d_r <= PINS_RST;
      for (int i = 0; i < 5; i++) deb_cnt_r[i] <= 16'h0000;
    end
    else if (aclken)
    begin
      pins_s1_r <= pins_raw;
      pins_s2_r <= pins_s1_r;
      pins_s3_r <= pins_s2_r;
      filt_d_r <= filt_r;
      for (int i = 0; i < 5; i++)
      begin
        if (pins_s2_r[i] != pins_s3_r[i] || pins_s3_r[i] == filt_r[i])
          deb_cnt_r[i] <= 16'h0000;
        else if (deb_cnt_r[i] == 16'(DEB_CYC_P - 1))
        begin
          filt_r[i] <= pins_s3_r[i];
          deb_cnt_r[i] <= 16'h0000;
        end
        else
          deb_cnt_r[i] <= 16'(deb_cnt_r[i] + 16'h0001);
      end
    end
  end

  // AXI4-Lite write and read channels
  logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  wire wr_fire = aw_got_r & w_got_r & ~bvalid_r;
  wire [31:0] wv = w_data_r;

  logic [3:0] ctrl_r;
  logic [15:0] rise_r, fall_r, ov_lim_r, oc_lim_r, op_lim_r;
  logic [7:0] irq_st_r, irq_msk_r;
  rio_trip_t trip_r;
  logic load_on_r, live_r, mismatch_r;

  wire wr_ctrl = wr_fire && aw_addr_r == A_CTRL;
  wire wr_thr = wr_fire && aw_addr_r == A_THRESH;
  wire wr_ov = wr_fire && aw_addr_r == A_OV_LIM;
  wire wr_oc = wr_fire && aw_addr_r == A_OC_LIM;
  wire wr_op = wr_fire && aw_addr_r == A_OP_LIM;
  wire wr_trip = wr_fire && aw_addr_r == A_TRIP;
  wire wr_ist = wr_fire && aw_addr_r == A_IRQ_ST;
  wire wr_msk = wr_fire && aw_addr_r == A_IRQ_MSK;
  wire wr_cmd = wr_fire && aw_addr_r == A_CMD;
  wire [31:0] ov_new = merge({16'h0000, ov_lim_r}, wv, w_strb_r);
  wire [31:0] oc_new = merge({16'h0000, oc_lim_r}, wv, w_strb_r);
  wire [31:0] op_new = merge({16'h0000, op_lim_r}, wv, w_strb_r);
  wire ov_ok = fits(ov_new[15:0], CAP_V);
  wire oc_ok = fits(oc_new[15:0], CAP_I);
  wire op_ok = fits(op_new[15:0], CAP_P);
  wire wr_known = wr_ctrl | wr_thr | wr_ov | wr_oc | wr_op | wr_trip | wr_ist | wr_msk
                  | wr_cmd | (aw_addr_r == A_STATUS);
  wire wr_bad = ~wr_known | (wr_ov & ~ov_ok) | (wr_oc & ~oc_ok) | (wr_op & ~op_ok);
  wire [31:0] ctrl_new = merge({28'h0, ctrl_r}, wv, w_strb_r);
  wire [31:0] msk_new = merge({24'h0, irq_msk_r}, wv, w_strb_r);

  // Read decode
  wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};
  wire [31:0] status_w = {22'h0, filt_r, mismatch_r, cv_mode, live_r, load_on_r, trip_r != 6'h0};
  wire rd_hit = ra <= A_CMD;
  wire [31:0] rd_data =
    ra == A_CTRL ? {28'h0, ctrl_r} :
    ra == A_THRESH ? {fall_r, rise_r} :
    ra == A_OV_LIM ? {16'h0, ov_lim_r} :
    ra == A_OC_LIM ? {16'h0, oc_lim_r} :
    ra == A_OP_LIM ? {16'h0, op_lim_r} :
    ra == A_TRIP ? {26'h0, trip_r} :
    ra == A_STATUS ? status_w :
    ra == A_IRQ_ST ? {24'h0, irq_st_r} :
    ra == A_IRQ_MSK ? {24'h0, irq_msk_r} : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {aw_got_r, w_got_r, bvalid_r, rvalid_r} <= 4'h0;
      {awready_r, wready_r, arready_r} <= 3'h7;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bresp_r <= RESP_OKAY;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else if (aclken)
    begin
      if (s_axi_awvalid && awready_r)
      begin
        aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
        aw_got_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_got_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_fire)
      begin
        {aw_got_r, w_got_r} <= 2'h0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
        {awready_r, wready_r} <= 2'h3;
      end
      if (s_axi_arvalid && arready_r)
      begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_data;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_r && s_axi_rready)
      begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= CTRL_RST;
      {fall_r, rise_r} <= {FALL_RST, RISE_RST};
      {ov_lim_r, oc_lim_r, op_lim_r} <= {OV_RST, OC_RST, OP_RST};
      irq_msk_r <= IRQ_MSK_RST;
    end
    else if (aclken)
    begin
      if (wr_ctrl) ctrl_r <= ctrl_new[3:0];
      if (wr_thr) {fall_r, rise_r} <= merge({fall_r, rise_r}, wv, w_strb_r);
      if (wr_ov && ov_ok) ov_lim_r <= ov_new[15:0];
      if (wr_oc && oc_ok) oc_lim_r <= oc_new[15:0];
      if (wr_op && op_ok) op_lim_r <= op_new[15:0];
      if (wr_msk) irq_msk_r <= msk_new[7:0];
    end
  end

  // Control pins and protections
  wire both_load = ~ctrl_r[CB_A_INH] & ~ctrl_r[CB_B_INH];
  wire pair_hi = filt_r.ctl_a & filt_r.ctl_b;
  wire pair_lo = ~filt_r.ctl_a & ~filt_r.ctl_b;
  wire pair_hi_d = filt_d_r.ctl_a & filt_d_r.ctl_b;
  wire pair_lo_d = ~filt_d_r.ctl_a & ~filt_d_r.ctl_b;
  wire ext_off = both_load & pair_hi & ~pair_hi_d;
  wire ext_on = both_load & pair_lo & ~pair_lo_d;
  wire inh_now = (ctrl_r[CB_A_INH] & ~filt_r.ctl_a) | (ctrl_r[CB_B_INH] & ~filt_r.ctl_b);
  wire mismatch_w = filt_r.topo == ctrl_r[CB_SERIES];
  wire trig_fall = ctrl_r[CB_PROG] & filt_d_r.trig & ~filt_r.trig;
  wire sw_on = wr_cmd & w_strb_r[0] & wv[CMD_ON];
  wire sw_off = wr_cmd & w_strb_r[0] & wv[CMD_OFF];
  wire rio_trip_t trip_set = '{inhibit: inh_now, fan: fan_abnormal, ot: temp_high,
                               sop: source_mode && meas_power > op_lim_r,
                               soc: source_mode && meas_current > oc_lim_r,
                               ov: meas_voltage > ov_lim_r};
  wire [5:0] trip_clr = wr_trip ? (wv[5:0] & {6{w_strb_r[0]}}) : 6'h00;
  wire [5:0] trip_nxt = (trip_r & ~trip_clr) | trip_set;
  wire block_on = (trip_r != 6'h0) | mismatch_r;
  wire on_req = sw_on | ext_on;
  wire off_req = sw_off | ext_off;
  wire load_on_nxt = (trip_nxt != 6'h0 || mismatch_w) ? 1'b0 : (off_req ? 1'b0 :
                     ((on_req & ~block_on) ? 1'b1 : load_on_r));
  wire live_nxt = meas_voltage > rise_r ? 1'b1 : (meas_voltage < fall_r ? 1'b0 : live_r);
  wire prot_any = trip_r.ov | trip_r.soc | trip_r.sop | trip_r.ot | trip_r.fan
                  | foldback | input_ov | input_uv;
  wire [7:0] irq_ev = {mismatch_w & ~mismatch_r, trig_fall, trip_nxt & ~trip_r};
  wire [7:0] irq_clr = wr_ist ? (wv[7:0] & {8{w_strb_r[0]}}) : 8'h00;
  wire [7:0] irq_st_nxt = (irq_st_r & ~irq_clr) | irq_ev;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trip_r <= 6'h00;
      {load_on_r, live_r, mismatch_r} <= 3'h0;
      irq_st_r <= 8'h00;
      {output_live_flag, output_enabled_status, regulation_mode_out, output_on} <= 4'h0;
      {overtemp_out_n, fault_n} <= 2'h3;
      {seq_advance, irq} <= 2'h0;
    end
    else if (aclken)
    begin
      trip_r <= trip_nxt;
      load_on_r <= load_on_nxt;
      live_r <= live_nxt;
      mismatch_r <= mismatch_w;
      irq_st_r <= irq_st_nxt;
      output_live_flag <= live_nxt;
      output_on <= load_on_nxt & ~filt_r.interlock;
      output_enabled_status <= load_on_nxt & ~filt_r.interlock;
      regulation_mode_out <= cv_mode;
      overtemp_out_n <= ~trip_r.ot;
      fault_n <= ~prot_any;
      seq_advance <= trig_fall;
      irq <= |(irq_st_nxt & irq_msk_r);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  default clocking cb @(posedge aclk iff aclken);
  endclocking
  default disable iff (!aresetn);

  a_live_rise: assert property (meas_voltage > rise_r |=> output_live_flag)
    else $error("live flag not raised above rise level");
  a_live_hold: assert property (meas_voltage <= rise_r && meas_voltage >= fall_r
    |=> output_live_flag == $past(output_live_flag))
    else $error("live flag moved inside hysteresis band");
  a_enable_state: assert property (output_enabled_status |-> load_on_r && !filt_d_r.interlock)
    else $error("enabled status without load on");
  a_mode_follow: assert property (##1 regulation_mode_out == $past(cv_mode))
    else $error("mode output does not follow regulation");
  a_pair_off: assert property (ext_off && !on_req |=> !load_on_r)
    else $error("control pair high did not switch off");
  a_inhibit_block: assert property (trip_r.inhibit |=> !load_on_r)
    else $error("load on while inhibit latched");
  a_inhibit_latch: assert property (trip_r.inhibit && !trip_clr[5] |=> trip_r.inhibit)
    else $error("inhibit cleared itself");
  a_fan_latch: assert property (trip_r.fan && !trip_clr[4] |=> trip_r.fan)
    else $error("fan trip not latched");
  a_fault_line: assert property (trip_r.ov || foldback |=> !fault_n)
    else $error("fault line high during protection");
  a_ot_out: assert property (trip_r.ot |=> !overtemp_out_n && !fault_n)
    else $error("overtemp lines not low");
  a_interlock_off: assert property (filt_r.interlock |=> !output_on)
    else $error("output on during interlock");
  a_ov_reject: assert property (wr_ov && !ov_ok |=> ov_lim_r == $past(ov_lim_r)
    && s_axi_bresp == RESP_SLVERR)
    else $error("over-cap voltage limit accepted");
  a_trig_pulse: assert property (trig_fall |=> seq_advance ##1 !seq_advance)
    else $error("sequence advance not a single pulse");
  a_sync_delay: assert property (filt_r != filt_d_r
    |-> ((filt_r ^ filt_d_r) & ($past(pins_s3_r) ^ filt_r)) == 5'h00)
    else $error("filtered input not from synchroniser");

  c_ext_on: cover property (ext_on ##1 load_on_r);
  c_inhibit: cover property (trip_set.inhibit ##1 trip_r.inhibit);
  c_seq: cover property (seq_advance);
  c_irq: cover property (irq);

endmodule : rio_top
`default_nettype wire

// ===== testbench/rio_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module rio_ext_model (
  // Clock
  input wire logic aclk,
  // Requests from the bench
  input wire logic pair_mode,
  input wire logic load_req,
  input wire logic inh_level,
  input wire logic trig_req,
  input wire logic topo_level,
  // Connector lines
  output logic line_a,
  output logic line_b,
  output logic trig_line,
  output logic topo_line
);
  initial
  begin
    line_a = 1'b1;
    line_b = 1'b1;
    trig_line = 1'b1;
    topo_line = 1'b1;
  end

  // Paired lines always move together; line a may serve as inhibit instead
  always @(posedge aclk)
  begin
    line_b <= ~load_req;
    line_a <= pair_mode ? ~load_req : inh_level;
    trig_line <= ~trig_req;
    topo_line <= topo_level;
  end
endmodule : rio_ext_model
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rio_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic aclken = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] meas_voltage = 16'h0000;
  logic [15:0] meas_current = 16'h0000;
  logic [15:0] meas_power = 16'h0000;
  logic source_mode = 1'b0, cv_mode = 1'b0, temp_high = 1'b0, fan_abnormal = 1'b0;
  logic foldback = 1'b0, input_ov = 1'b0, input_uv = 1'b0, interlock_in = 1'b0;
  logic pair_mode = 1'b1, load_req = 1'b0, inh_level = 1'b1, trig_req = 1'b0;
  logic topo_level = 1'b1;
  logic line_a, line_b, trig_line, topo_line;
  logic output_live_flag, output_enabled_status, regulation_mode_out, overtemp_out_n;
  logic fault_n, output_on, seq_advance, irq;
  logic [31:0] exp_d[$];
  logic [1:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [15:0] lfsr_r = 16'h0042;
  int n_fail = 0;
  int total_checks = 0;
  int n_adv = 0;
  logic [31:0] rd_mask = 32'hFFFFFFFF;

  always #5 aclk = ~aclk;

  rio_top #(.DEB_CYC_P(4)) dut_u (.aclk, .aresetn, .aclken, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_control_in_a(line_a), .ext_control_in_b(line_b),
    .topology_key(topo_line), .sequence_trigger_in(trig_line), .interlock_in,
    .meas_voltage, .meas_current, .meas_power, .source_mode, .cv_mode, .temp_high,
    .fan_abnormal, .foldback, .input_ov, .input_uv, .output_live_flag,
    .output_enabled_status, .regulation_mode_out, .overtemp_out_n, .fault_n,
    .output_on, .seq_advance, .irq);

  rio_ext_model ext_u (.aclk, .pair_mode, .load_req, .inh_level, .trig_req,
    .topo_level, .line_a, .line_b, .trig_line, .topo_line);

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check_word

  task automatic check_pin(input string nm, input logic e, input logic g);
    check_word(nm, {31'h0, e}, {31'h0, g});
  endtask : check_pin

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    exp_b.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    exp_d.push_back(e & rd_mask);
    exp_r.push_back(er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
  endtask : axi_read

  // Drives one protection cause; all other measurements get harmless random values
  task automatic set_trip(input int k, input logic v);
    lfsr_r = lfsr_next(lfsr_r);
    source_mode <= v;
    meas_voltage <= (k == 0 && v) ? 16'hFFFF : (lfsr_r & 16'h0FFF);
    meas_current <= (k == 1 && v) ? 16'hFFFF : (lfsr_r & 16'h0FFF);
    meas_power <= (k == 2 && v) ? 16'hFFFF : (lfsr_r & 16'h0FFF);
    temp_high <= (k == 3) && v;
    fan_abnormal <= (k == 4) && v;
  endtask : set_trip

  // Response monitor: oldest note is compared as each result appears
  always @(posedge aclk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_d.size() > 0)
    begin
      check_word("rdata", exp_d.pop_front(), s_axi_rdata & rd_mask);
      check_word("rresp", {30'h0, exp_r.pop_front()}, {30'h0, s_axi_rresp});
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && exp_b.size() > 0)
      check_word("bresp", {30'h0, exp_b.pop_front()}, {30'h0, s_axi_bresp});
    if (seq_advance === 1'b1)
      n_adv++;
  end

  initial
  begin
    cyc(20000);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    int k;
    int base;
    cyc(5);
    aresetn <= 1'b1;
    cyc(1);
    check_pin("fault_n", 1'b1, fault_n);
    check_pin("overtemp_out_n", 1'b1, overtemp_out_n);
    axi_read(A_THRESH, {FALL_RST, RISE_RST}, RESP_OKAY);
    axi_read(8'h28, 32'h0, RESP_SLVERR);
    axi_write(A_OV_LIM, {16'h0, CAP_V[15:0] + 16'h0001}, RESP_SLVERR);
    axi_read(A_OV_LIM, {16'h0, OV_RST}, RESP_OKAY);
    axi_write(A_OV_LIM, {16'h0, CAP_V[15:0]}, RESP_OKAY);
    axi_write(A_OC_LIM, {16'h0, CAP_I[15:0] + 16'h0001}, RESP_SLVERR);
    axi_write(A_OP_LIM, {16'h0, CAP_P[15:0] + 16'h0001}, RESP_SLVERR);
    axi_read(A_OP_LIM, {16'h0, OP_RST}, RESP_OKAY);
    $display("[TEST] registers done");
    meas_voltage <= RISE_RST + 16'h0001;
    cyc(3);
    check_pin("live", 1'b1, output_live_flag);
    meas_voltage <= FALL_RST + 16'h0001;
    cyc(3);
    check_pin("live", 1'b1, output_live_flag);
    meas_voltage <= FALL_RST - 16'h0001;
    cyc(3);
    check_pin("live", 1'b0, output_live_flag);
    meas_voltage <= RISE_RST;
    cyc(3);
    check_pin("live", 1'b0, output_live_flag);
    aclken <= 1'b0;
    meas_voltage <= RISE_RST + 16'h0001;
    cyc(3);
    check_pin("live frozen", 1'b0, output_live_flag);
    aclken <= 1'b1;
    cyc(3);
    check_pin("live", 1'b1, output_live_flag);
    for (k = 1; k >= 0; k--)
    begin
      cv_mode <= k[0];
      cyc(3);
      check_pin("mode", k[0], regulation_mode_out);
    end
    load_req <= 1'b1;
    cyc(20);
    check_pin("output_on", 1'b1, output_on);
    check_pin("enabled", 1'b1, output_enabled_status);
    interlock_in <= 1'b1;
    cyc(20);
    check_pin("enabled", 1'b0, output_enabled_status);
    interlock_in <= 1'b0;
    cyc(20);
    check_pin("enabled", 1'b1, output_enabled_status);
    load_req <= 1'b0;
    cyc(20);
    check_pin("output_on", 1'b0, output_on);
    $display("[TEST] pins done");
    meas_current <= 16'hFFFF;
    meas_power <= 16'hFFFF;
    cyc(4);
    check_pin("fault_n", 1'b1, fault_n);
    rd_mask = 32'h0000003F;
    for (k = 0; k < 5; k++)
    begin
      set_trip(k, 1'b1);
      cyc(4);
      check_pin("fault_n", 1'b0, fault_n);
      check_pin("overtemp_out_n", k != 3, overtemp_out_n);
      axi_read(A_TRIP, 32'h1 << k, RESP_OKAY);
      set_trip(k, 1'b0);
      cyc(4);
      check_pin("fault_n", 1'b0, fault_n);
      axi_write(A_TRIP, 32'h1 << k, RESP_OKAY);
      cyc(2);
      check_pin("fault_n", 1'b1, fault_n);
    end
    for (k = 0; k < 3; k++)
    begin
      {input_uv, input_ov, foldback} <= 3'h1 << k;
      cyc(3);
      check_pin("fault_n", 1'b0, fault_n);
      {input_uv, input_ov, foldback} <= 3'h0;
      cyc(3);
      check_pin("fault_n", 1'b1, fault_n);
    end
    axi_write(A_IRQ_ST, 32'h000000FF, RESP_OKAY);
    axi_write(A_IRQ_MSK, 32'h00000008, RESP_OKAY);
    set_trip(4, 1'b1);
    cyc(4);
    check_pin("irq", 1'b0, irq);
    set_trip(3, 1'b1);
    cyc(4);
    check_pin("irq", 1'b1, irq);
    axi_write(A_IRQ_ST, 32'h00000008, RESP_OKAY);
    cyc(2);
    check_pin("irq", 1'b0, irq);
    set_trip(3, 1'b0);
    axi_write(A_TRIP, 32'h00000018, RESP_OKAY);
    $display("[TEST] protections done");
    axi_write(A_CTRL, 32'h00000002, RESP_OKAY);
    pair_mode <= 1'b0;
    axi_write(A_CMD, 32'h00000001, RESP_OKAY);
    cyc(3);
    check_pin("output_on", 1'b1, output_on);
    inh_level <= 1'b0;
    cyc(20);
    check_pin("output_on", 1'b0, output_on);
    axi_read(A_TRIP, 32'h00000020, RESP_OKAY);
    inh_level <= 1'b1;
    cyc(20);
    axi_write(A_CMD, 32'h00000001, RESP_OKAY);
    cyc(3);
    check_pin("output_on", 1'b0, output_on);
    axi_write(A_TRIP, 32'h00000020, RESP_OKAY);
    axi_write(A_CMD, 32'h00000001, RESP_OKAY);
    cyc(3);
    check_pin("output_on", 1'b1, output_on);
    topo_level <= 1'b0;
    cyc(20);
    check_pin("output_on", 1'b0, output_on);
    rd_mask = 32'h00000010;
    axi_read(A_STATUS, 32'h00000010, RESP_OKAY);
    axi_write(A_CTRL, 32'h00000008, RESP_OKAY);
    cyc(3);
    axi_read(A_STATUS, 32'h00000000, RESP_OKAY);
    $display("[TEST] inhibit and topology done");
    for (k = 0; k < 3; k++)
    begin
      axi_write(A_CTRL, {31'h0, k != 2}, RESP_OKAY);
      base = n_adv;
      trig_req <= 1'b1;
      cyc(k == 0 ? 2 : 20);
      trig_req <= 1'b0;
      cyc(20);
      check_word("advance count", {31'h0, k == 1}, n_adv - base);
    end
    $display("[TEST] trigger done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
